/* include/xmap_params.svh */
// Offsets, field positions, reset values and address windows of the xdata paging block
// Included by the top-level design module xmap_top only
`ifndef XMAP_PARAMS_SVH
`define XMAP_PARAMS_SVH
`define XMAP_ADDR_PAGE 8'h93
`define XMAP_ADDR_ARBCTL 8'hC7
`define XMAP_ADDR_BANK 8'h9F
`define XMAP_RST_PAGE 8'h00
`define XMAP_RST_BANK 2'h1
`define XMAP_RST_RSV 1'b1
`define XMAP_BIT_UNIF 6
`define XMAP_BIT_BANK_LO 4
`define XMAP_BIT_CDIS 1
`define XMAP_BIT_RSV 0
`define XMAP_WIN_BASE 16'h8000
`define XMAP_RADIO_BASE 16'hDF00
`define XMAP_RAM_BASE 16'hE000
`endif

/* include/xmap_pkg.sv */
// Types shared by the xdata paging and code mapping modules
// Assumes xmap_params.svh on the include path
package xmap_pkg;
  typedef enum logic [3:0] {
    XMAP_T_NONE = 4'b0001,
    XMAP_T_FLASH = 4'b0010,
    XMAP_T_RAM = 4'b0100,
    XMAP_T_RADIO = 4'b1000
  } xmap_target_t;
  typedef struct packed {
    xmap_target_t target;
    logic [16:0] addr;
  } xmap_phys_t;
endpackage

/* hw/xmap_arbiter.sv */
// Memory arbiter: serves processor and DMA requests to the physical memories
// Assumes requests are already mapped to a physical target and address
`timescale 1ns/1ns
`default_nettype none
module xmap_arbiter (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Processor request
  input wire logic cpu_req,
  input wire logic cpu_we,
  input wire xmap_pkg::xmap_phys_t cpu_phys,
  input wire logic [7:0] cpu_wdata,
  // DMA request
  input wire logic dma_req,
  input wire logic dma_we,
  input wire xmap_pkg::xmap_phys_t dma_phys,
  input wire logic [7:0] dma_wdata,
  // Memory side
  output logic mem_req,
  output logic mem_we,
  output xmap_pkg::xmap_phys_t mem_phys,
  output logic [7:0] mem_wdata,
  output logic cpu_ack,
  output logic dma_ack
);
  typedef struct packed {
    logic mem_req;
    logic mem_we;
    xmap_pkg::xmap_phys_t mem_phys;
    logic [7:0] mem_wdata;
    logic cpu_ack;
    logic dma_ack;
  } xmap_arb_state_t;

  xmap_arb_state_t st;
  xmap_arb_state_t next_st;
  logic cpu_go;
  logic dma_go;

  always_comb begin
    // A requester whose ack stands is not taken again that cycle
    cpu_go = cpu_req && !st.cpu_ack;
    dma_go = dma_req && !st.dma_ack && !cpu_go;
    next_st = st;
    next_st.mem_req = cpu_go || dma_go; // R5
    next_st.cpu_ack = cpu_go;
    next_st.dma_ack = dma_go;
    next_st.mem_we = 1'b0;
    if (cpu_go) begin
      next_st.mem_we = cpu_we;
      next_st.mem_phys = cpu_phys;
      next_st.mem_wdata = cpu_wdata;
    end else if (dma_go) begin
      next_st.mem_we = dma_we;
      next_st.mem_phys = dma_phys;
      next_st.mem_wdata = dma_wdata;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st <= '{1'b0, 1'b0, '{xmap_pkg::XMAP_T_NONE, 17'h0_0000}, 8'h00, 1'b0, 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign mem_req = st.mem_req;
  assign mem_we = st.mem_we;
  assign mem_phys = st.mem_phys;
  assign mem_wdata = st.mem_wdata;
  assign cpu_ack = st.cpu_ack;
  assign dma_ack = st.dma_ack;

  dma_served_a: assert property (@(posedge clock) disable iff (!resetn)
    dma_req && !cpu_req && !dma_ack |=> dma_ack && mem_req) // R5
    else $error("idle DMA request not served");
  cpu_first_a: assert property (@(posedge clock) disable iff (!resetn)
    cpu_req && !cpu_ack |=> cpu_ack && !dma_ack && mem_phys == $past(cpu_phys)) // R5
    else $error("processor request not served first");
  dma_cover_c: cover property (@(posedge clock) disable iff (!resetn)
    cpu_req && dma_req && !cpu_ack ##1 cpu_ack ##1 dma_ack);
endmodule
`default_nettype wire

/* hw/xmap_top.sv */
// Xdata paging, unified code mapping and flash bank selection on the processor side
// Assumes the register port and both requesters run on this clock and reset
//
// Notes on behaviour
// R1: An indirect xdata move takes its upper address byte from the page-select register.
// R2: An indirect xdata move takes its lower address byte from the chosen index register.
// R3: The page-select register is eight read-write bits that reset to zero.
// R4: The port two latch never supplies the upper byte of an indirect xdata move.
// R5: The arbiter takes and serves requests of both the processor and the DMA engine.
// R6: Software enables unified mapping before running code held in RAM.
// R7: With unified mapping off, code addresses 0x8000 to 0xFFFF go to the flash bank chosen by the bank field.
// R8: The bank field is one store seen in both the bank register and the arbiter control.
// R9: Unified mapping shows all memories in code space, otherwise only flash.
// R10: The bank field picks one of four flash banks of 32 KB.
// R11: The radio registers are decoded in xdata space from base DF00h.
`timescale 1ns/1ns
`default_nettype none
`include "xmap_params.svh"
module xmap_top (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Special function register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // Processor request
  input wire logic cpu_req,
  input wire logic cpu_code,
  input wire logic cpu_indirect,
  input wire logic cpu_we,
  input wire logic [15:0] cpu_addr,
  input wire logic [7:0] index_register,
  input wire logic [7:0] cpu_wdata,
  // DMA request, always xdata space
  input wire logic dma_req,
  input wire logic dma_we,
  input wire logic [15:0] dma_addr,
  input wire logic [7:0] dma_wdata,
  // Physical memory side
  output logic mem_req,
  output logic mem_we,
  output logic [3:0] mem_target,
  output logic [16:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic cpu_ack,
  output logic dma_ack,
  // Control levels
  output logic unified_map_enable,
  output logic cache_disable
);
  typedef struct packed {
    logic [7:0] xdata_page_select;
    logic unif;
    logic [1:0] bank_select_field;
    logic cdis;
    logic rsv;
    logic [7:0] rdata;
  } xmap_state_t;

  xmap_state_t st;
  xmap_state_t next_st;
  logic [15:0] cpu_logical;
  xmap_pkg::xmap_phys_t cpu_phys;
  xmap_pkg::xmap_phys_t dma_phys;
  xmap_pkg::xmap_phys_t arb_phys;

  function automatic xmap_pkg::xmap_phys_t map_addr(input logic code, input logic [15:0] a,
      input logic unif, input logic [1:0] bank);
    xmap_pkg::xmap_phys_t p;
    p.target = xmap_pkg::XMAP_T_FLASH;
    p.addr = {2'b00, a[14:0]};
    if (a >= `XMAP_WIN_BASE) begin
      p.addr = {bank, a[14:0]}; // R7 R10
    end
    if ((!code || unif) && a >= `XMAP_RAM_BASE) begin
      p.target = xmap_pkg::XMAP_T_RAM; // R9
      p.addr = {4'h0, a[12:0]};
    end else if ((!code || unif) && a[15:8] == 8'(`XMAP_RADIO_BASE >> 8)) begin
      p.target = xmap_pkg::XMAP_T_RADIO; // R11 R9
      p.addr = {9'h000, a[7:0]};
    end
    return p;
  endfunction

  function automatic logic [7:0] arbctl_image(input xmap_state_t s);
    logic [7:0] v;
    v = 8'h00;
    v[`XMAP_BIT_UNIF] = s.unif;
    v[`XMAP_BIT_BANK_LO +: 2] = s.bank_select_field; // R8
    v[`XMAP_BIT_CDIS] = s.cdis;
    v[`XMAP_BIT_RSV] = s.rsv;
    return v;
  endfunction

  always_comb begin
    // Indirect xdata moves use page register and index register only
    if (cpu_indirect && !cpu_code) begin
      cpu_logical = {st.xdata_page_select, index_register}; // R1 R2 R4
    end else begin
      cpu_logical = cpu_addr;
    end
    cpu_phys = map_addr(cpu_code, cpu_logical, st.unif, st.bank_select_field);
    dma_phys = map_addr(1'b0, dma_addr, st.unif, st.bank_select_field);
  end

  always_comb begin
    next_st = st;
    if (sfr_wr) begin
      case (sfr_addr)
        `XMAP_ADDR_PAGE: begin
          next_st.xdata_page_select = sfr_wdata; // R3
        end
        `XMAP_ADDR_BANK: begin
          next_st.bank_select_field = sfr_wdata[1:0]; // R8
        end
        `XMAP_ADDR_ARBCTL: begin
          next_st.unif = sfr_wdata[`XMAP_BIT_UNIF];
          next_st.bank_select_field = sfr_wdata[`XMAP_BIT_BANK_LO +: 2]; // R8
          next_st.cdis = sfr_wdata[`XMAP_BIT_CDIS];
          next_st.rsv = sfr_wdata[`XMAP_BIT_RSV];
        end
        default: begin
        end
      endcase
    end
    if (sfr_rd) begin
      case (sfr_addr)
        `XMAP_ADDR_PAGE: begin
          next_st.rdata = st.xdata_page_select; // R3
        end
        `XMAP_ADDR_BANK: begin
          next_st.rdata = {6'h00, st.bank_select_field}; // R8
        end
        `XMAP_ADDR_ARBCTL: begin
          next_st.rdata = arbctl_image(st);
        end
        default: begin
          next_st.rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st <= '{`XMAP_RST_PAGE, 1'b0, `XMAP_RST_BANK, 1'b0, `XMAP_RST_RSV, 8'h00}; // R3
    end else begin
      st <= next_st;
    end
  end

  // Both requesters reach every physical memory through the arbiter
  xmap_arbiter u_arb (
    .clock(clock),
    .resetn(resetn),
    .cpu_req(cpu_req),
    .cpu_we(cpu_we),
    .cpu_phys(cpu_phys),
    .cpu_wdata(cpu_wdata),
    .dma_req(dma_req),
    .dma_we(dma_we),
    .dma_phys(dma_phys),
    .dma_wdata(dma_wdata),
    .mem_req(mem_req),
    .mem_we(mem_we),
    .mem_phys(arb_phys),
    .mem_wdata(mem_wdata),
    .cpu_ack(cpu_ack),
    .dma_ack(dma_ack)
  ); // R5

  assign mem_target = arb_phys.target;
  assign mem_addr = arb_phys.addr;
  assign sfr_rdata = st.rdata;
  assign unified_map_enable = st.unif;
  assign cache_disable = st.cdis;

  page_upper_a: assert property (@(posedge clock) disable iff (!resetn) // R1
    cpu_ack && $past(cpu_indirect && !cpu_code)
    && $past(st.xdata_page_select) >= 8'(`XMAP_RAM_BASE >> 8)
    |-> mem_target == xmap_pkg::XMAP_T_RAM
    && mem_addr[12:8] == $past(st.xdata_page_select[4:0]))
    else $error("indirect move upper byte not from page register");
  index_lower_a: assert property (@(posedge clock) disable iff (!resetn) // R2
    cpu_ack && $past(cpu_indirect && !cpu_code) |-> mem_addr[7:0] == $past(index_register))
    else $error("indirect move lower byte not from index register");
  page_write_a: assert property (@(posedge clock) disable iff (!resetn) // R3
    sfr_wr && sfr_addr == `XMAP_ADDR_PAGE ##1 sfr_rd && sfr_addr == `XMAP_ADDR_PAGE && !sfr_wr
    |=> sfr_rdata == $past(sfr_wdata, 2))
    else $error("page register readback wrong");
  port_latch_a: assert property (@(posedge clock) disable iff (!resetn) // R4
    cpu_ack && $past(cpu_indirect && !cpu_code)
    && $past(st.xdata_page_select) < 8'(`XMAP_RADIO_BASE >> 8)
    |-> mem_addr[14:8] == $past(st.xdata_page_select[6:0]))
    else $error("indirect upper byte taken from elsewhere");
  bank_window_a: assert property (@(posedge clock) disable iff (!resetn) // R7
    cpu_ack && $past(cpu_code && !st.unif && cpu_addr[15])
    |-> mem_target == xmap_pkg::XMAP_T_FLASH
    && mem_addr[16:15] == $past(st.bank_select_field))
    else $error("upper code window not mapped to selected bank");
  bank_alias_a: assert property (@(posedge clock) disable iff (!resetn) // R8
    sfr_wr && sfr_addr == `XMAP_ADDR_BANK ##1 sfr_rd && sfr_addr == `XMAP_ADDR_ARBCTL && !sfr_wr
    |=> sfr_rdata[`XMAP_BIT_BANK_LO +: 2] == $past(sfr_wdata[1:0], 2))
    else $error("bank field alias not seen in arbiter control");
  flash_only_a: assert property (@(posedge clock) disable iff (!resetn) // R9
    cpu_ack && $past(cpu_code && !st.unif) |-> mem_target == xmap_pkg::XMAP_T_FLASH)
    else $error("non-flash memory in code space without unified mapping");
  low_bank_a: assert property (@(posedge clock) disable iff (!resetn) // R10
    cpu_ack && $past(cpu_code && !cpu_addr[15]) |-> mem_addr[16:15] == 2'b00)
    else $error("lower code half left bank zero");
  radio_base_a: assert property (@(posedge clock) disable iff (!resetn) // R11
    dma_ack && $past(dma_addr[15:8]) == 8'(`XMAP_RADIO_BASE >> 8)
    |-> mem_target == xmap_pkg::XMAP_T_RADIO
    && mem_addr[7:0] == $past(dma_addr[7:0]))
    else $error("radio window decode wrong");

  unif_cover_c: cover property (@(posedge clock) disable iff (!resetn)
    cpu_ack && st.unif && mem_target == xmap_pkg::XMAP_T_RAM);
  indirect_cover_c: cover property (@(posedge clock) disable iff (!resetn)
    cpu_ack && $past(cpu_indirect));
endmodule
`default_nettype wire

/* testbench/xmap_dma_model.sv */
// DMA requester model facing the arbiter
// Assumes the block's clock and reset; the bench pulses start for one cycle
`timescale 1ns/1ns
`default_nettype none
module xmap_dma_model (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Command from the bench
  input wire logic start,
  input wire logic [15:0] start_addr,
  // Requester side
  output logic dma_req,
  output logic dma_we,
  output logic [15:0] dma_addr,
  output logic [7:0] dma_wdata,
  input wire logic dma_ack
);
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      dma_req <= 1'b0;
      dma_we <= 1'b0;
      dma_addr <= 16'h0000;
      dma_wdata <= 8'h00;
    end else if (start) begin
      dma_req <= 1'b1;
      dma_we <= start_addr[0];
      dma_addr <= start_addr;
      dma_wdata <= start_addr[15:8];
    end else if (dma_ack) begin
      // Released lines stop showing the old request
      dma_req <= 1'b0;
      dma_we <= ~dma_we;
      dma_addr <= ~dma_addr;
      dma_wdata <= ~dma_wdata;
    end
  end
endmodule
`default_nettype wire

/* testbench/xdata_paging_and_code_mapping_tb_top.sv */
// Self-checking bench for xdata paging, code mapping and arbitration
// Assumes xmap_top and the DMA requester model are compiled before it
`timescale 1ns/1ns
`default_nettype none
module xdata_paging_and_code_mapping_tb_top;
  logic clock, resetn, sfr_wr, sfr_rd, cpu_req, cpu_code, cpu_indirect, cpu_we;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, index_register, cpu_wdata, dma_wdata, mem_wdata;
  logic [15:0] cpu_addr, dma_addr, dma_start_addr;
  logic dma_req, dma_we, dma_start, mem_req, mem_we, cpu_ack, dma_ack;
  logic unified_map_enable, cache_disable;
  logic [3:0] mem_target;
  logic [16:0] mem_addr;
  logic [7:0] m_page, d;
  logic m_unif;
  logic [1:0] m_bank;
  logic [31:0] rnd;
  int err_total, samples_checked;
  time t_cpu, t_dma;

  xmap_top dut (.clock(clock), .resetn(resetn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .cpu_req(cpu_req),
    .cpu_code(cpu_code), .cpu_indirect(cpu_indirect), .cpu_we(cpu_we), .cpu_addr(cpu_addr),
    .index_register(index_register), .cpu_wdata(cpu_wdata), .dma_req(dma_req),
    .dma_we(dma_we), .dma_addr(dma_addr), .dma_wdata(dma_wdata), .mem_req(mem_req),
    .mem_we(mem_we), .mem_target(mem_target), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .cpu_ack(cpu_ack), .dma_ack(dma_ack), .unified_map_enable(unified_map_enable),
    .cache_disable(cache_disable));
  xmap_dma_model partner (.clock(clock), .resetn(resetn), .start(dma_start),
    .start_addr(dma_start_addr), .dma_req(dma_req), .dma_we(dma_we), .dma_addr(dma_addr),
    .dma_wdata(dma_wdata), .dma_ack(dma_ack));

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Expected target and physical address from the mirrored registers
  function automatic logic [20:0] exp_map(input logic code, input logic ind,
      input logic [15:0] la, input logic [7:0] idx);
    logic [15:0] a;
    a = (!code && ind) ? {m_page, idx} : la;
    if ((!code || m_unif) && a[15:8] == 8'hDF) return {4'h8, 9'h000, a[7:0]};
    if ((!code || m_unif) && a >= 16'hE000) return {4'h4, 4'h0, a[12:0]};
    if (a[15]) return {4'h2, m_bank, a[14:0]};
    return {4'h2, 2'b00, a[14:0]};
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic check_mem(input logic [20:0] e, input string what);
    logic [16:0] m;
    m = (e[20:17] == 4'h8) ? 17'h0_00FF : (e[20:17] == 4'h4) ? 17'h0_1FFF : 17'h1_FFFF;
    check({mem_req, mem_target, mem_addr & m}, {1'b1, e[20:17], e[16:0] & m}, what);
  endtask

  task automatic sfr_write(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock); #1;
    sfr_addr = a;
    sfr_wdata = v;
    sfr_wr = 1'b1;
    @(posedge clock); #1;
    sfr_wr = 1'b0;
    mirror_write(a, v);
  endtask

  // Mirrors of the writable fields for expected mappings
  task automatic mirror_write(input logic [7:0] a, input logic [7:0] v);
    if (a == 8'h93) m_page = v;
    if (a == 8'hC7) {m_unif, m_bank} = v[6:4];
    if (a == 8'h9F) m_bank = v[1:0];
  endtask

  // Write strobe followed at once by a read strobe, no idle cycle between
  task automatic sfr_wr_rd(input logic [7:0] wa, input logic [7:0] wv, input logic [7:0] ra,
      output logic [7:0] v);
    @(posedge clock); #1;
    sfr_addr = wa;
    sfr_wdata = wv;
    sfr_wr = 1'b1;
    @(posedge clock); #1;
    sfr_wr = 1'b0;
    sfr_addr = ra;
    sfr_rd = 1'b1;
    mirror_write(wa, wv);
    @(posedge clock); #1;
    sfr_rd = 1'b0;
    v = sfr_rdata;
  endtask

  task automatic sfr_read(input logic [7:0] a, output logic [7:0] v);
    @(posedge clock); #1;
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(posedge clock); #1;
    sfr_rd = 1'b0;
    v = sfr_rdata;
  endtask

  task automatic cpu_access(input logic code, input logic ind, input logic [15:0] a,
      input logic [7:0] idx);
    logic [20:0] e;
    e = exp_map(code, ind, a, idx);
    rnd = lfsr_next(rnd);
    @(posedge clock); #1;
    {cpu_req, cpu_code, cpu_indirect, cpu_addr, index_register} = {1'b1, code, ind, a, idx};
    {cpu_we, cpu_wdata} = {~code & rnd[3], rnd[11:4]};
    for (int i = 0; i < 4 && cpu_ack !== 1'b1; i++) begin
      @(posedge clock); #1;
    end
    cpu_req = 1'b0;
    t_cpu = $time;
    check_mem(e, "cpu map");
    check({mem_we, mem_wdata}, {cpu_we, cpu_wdata}, "cpu write data");
  endtask

  task automatic dma_access(input logic [15:0] a);
    dma_start_addr = a;
    dma_start = 1'b1;
    @(posedge clock); #1;
    dma_start = 1'b0;
    for (int i = 0; i < 8 && dma_ack !== 1'b1; i++) begin
      @(posedge clock); #1;
    end
    t_dma = $time;
    check_mem(exp_map(1'b0, 1'b0, a, 8'h00), "dma map");
    check({mem_we, mem_wdata}, {a[0], a[15:8]}, "dma write data");
  endtask

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  initial begin
    #200000;
    err_total++;
    complete_run();
  end

  initial begin
    {resetn, sfr_wr, sfr_rd, cpu_req, cpu_code, cpu_indirect, cpu_we, dma_start} = 8'h00;
    {sfr_addr, sfr_wdata, index_register, cpu_wdata, cpu_addr, dma_start_addr} = 64'h0;
    {m_page, m_unif, m_bank} = 11'h001;
    rnd = 32'h0000_D6CF;
    err_total = 0;
    samples_checked = 0;
    repeat (5) @(posedge clock);
    #1 resetn = 1'b1;
    sfr_read(8'h93, d); check(d, 8'h00, "page reset");
    sfr_read(8'hC7, d); check(d, 8'h11, "arbiter control reset");
    sfr_read(8'h9F, d); check(d, 8'h01, "bank register reset");
    sfr_read(8'h55, d); check(d, 8'h00, "unmapped read");
    sfr_write(8'hC7, 8'hFF);
    sfr_read(8'hC7, d); check(d, 8'h73, "arbiter control bits");
    check({unified_map_enable, cache_disable}, 2'b11, "control levels");
    sfr_wr_rd(8'h9F, 8'h02, 8'hC7, d); check(d, 8'h63, "alias via bank register");
    sfr_write(8'hC7, 8'h31);
    sfr_read(8'h9F, d); check(d, 8'h03, "alias via arbiter control");
    for (int b = 0; b < 4; b++) begin
      sfr_write(8'h9F, 8'(b));
      cpu_access(1'b1, 1'b0, 16'h8000, 8'h00);
      cpu_access(1'b1, 1'b0, 16'hFFFF, 8'h00);
    end
    cpu_access(1'b1, 1'b0, 16'hE010, 8'h00);
    sfr_write(8'hC7, 8'h51);
    cpu_access(1'b1, 1'b0, 16'hE010, 8'h00);
    cpu_access(1'b1, 1'b0, 16'hDF05, 8'h00);
    sfr_write(8'h93, 8'hDF);
    cpu_access(1'b0, 1'b1, 16'h1234, 8'h05);
    sfr_write(8'h93, 8'hE1);
    cpu_access(1'b0, 1'b1, 16'hFF00, 8'h34);
    sfr_read(8'h93, d); check(d, 8'hE1, "page readback");
    sfr_wr_rd(8'h93, 8'h12, 8'h93, d); check(d, 8'h12, "page write then read");
    cpu_access(1'b0, 1'b1, 16'hABCD, 8'h56);
    dma_access(16'hDF33);
    for (int i = 0; i < 40; i++) begin
      rnd = lfsr_next(rnd);
      if (rnd[5:4] == 2'b00) sfr_write(8'h93, rnd[15:8]);
      if (rnd[5:4] == 2'b01) sfr_write(8'hC7, rnd[23:16]);
      cpu_access(rnd[0], rnd[1], rnd[31:16], rnd[15:8]);
      dma_access(rnd[23:8]);
    end
    fork
      dma_access(16'hE123);
      cpu_access(1'b0, 1'b0, 16'hDF20, 8'h00);
    join
    check(t_dma > t_cpu, 1'b1, "processor served before DMA");
    complete_run();
  end
endmodule
`default_nettype wire
